// [include/tcdp_params.svh]
// constants for the telephone codec digital ports: offsets, fields, resets, timing
// assumes the user includes it by bare name; counts derive from the 4 ns system clock
`ifndef TCDP_PARAMS_SVH
`define TCDP_PARAMS_SVH

`define TCDP_MCLK_NS 4
`define TCDP_FSYNC_NS 125000
`define TCDP_FSYNC_CYC (`TCDP_FSYNC_NS / `TCDP_MCLK_NS)
`define TCDP_FSYNC_TOL_NS 1000
`define TCDP_FSYNC_TOL_CYC (`TCDP_FSYNC_TOL_NS / `TCDP_MCLK_NS)
`define TCDP_BCLK_STALL_NS 10000
`define TCDP_BCLK_STALL_CYC ((`TCDP_BCLK_STALL_NS + `TCDP_MCLK_NS - 1) / `TCDP_MCLK_NS)

`define TCDP_ADDR_ACC 4'h7
`define TCDP_ADDR_PAR 4'h8
`define TCDP_ADDR_TONE 4'hE
`define TCDP_ADDR_PCM 4'hF
`define TCDP_RST_ACC 5'h00
`define TCDP_RST_PAR 5'h00
`define TCDP_RST_TONE 5'h07
`define TCDP_RST_PCM 2'h0
`define TCDP_ACC_SW_BIT 0
`define TCDP_TONE_DIV_LSB 3
`define TCDP_WORD_BITS 9
`define TCDP_ADDR_LSB 5
`define TCDP_BITS_COMP 5'h08
`define TCDP_BITS_LIN 5'h10

`define TCDP_H_CTRL 4'h0
`define TCDP_H_CMD 4'h1
`define TCDP_H_STAT 4'h2
`define TCDP_H_TX 4'h3
`define TCDP_H_RX 4'h4
`define TCDP_H_CTRL_RST 16'h0040
`define TCDP_HC_LINK_EN 0
`define TCDP_HC_LINEAR 1
`define TCDP_HC_PS_LSB 2
`define TCDP_HC_GATE 5
`define TCDP_HC_LRST_N 6
`define TCDP_HS_BUSY 0
`define TCDP_HS_RX_NEW 1

`define TCDP_H_BCLK_NS 488
`define TCDP_H_BCLK_HALF_CYC (`TCDP_H_BCLK_NS / (2 * `TCDP_MCLK_NS))
`define TCDP_FRAME_BITS 256
`define TCDP_H_SCLK_NS 128
`define TCDP_H_SCLK_HALF_CYC (`TCDP_H_SCLK_NS / (2 * `TCDP_MCLK_NS))
`define TCDP_H_STB_NS 64
`define TCDP_H_STB_CYC ((`TCDP_H_STB_NS + `TCDP_MCLK_NS - 1) / `TCDP_MCLK_NS)
`define TCDP_H_TREF_NS 64
`define TCDP_H_TREF_HALF_CYC (`TCDP_H_TREF_NS / (2 * `TCDP_MCLK_NS))

`endif

// [include/tcdp_pkg.sv]
// types shared by both ends of the telephone codec digital ports
// assumes nothing beyond a SystemVerilog compiler
package tcdp_pkg;
	typedef enum logic [1:0] {
		TCDP_PCM_MULAW = 2'h0,
		TCDP_PCM_LINEAR = 2'h1,
		TCDP_PCM_ALAW = 2'h2,
		TCDP_PCM_RSVD = 2'h3
	} tcdp_pcm_mode_t;
	typedef enum logic [1:0] {
		TCDP_PWR_OFF = 2'h0,
		TCDP_PWR_VREF = 2'h1,
		TCDP_PWR_TONE = 2'h2,
		TCDP_PWR_ALL = 2'h3
	} tcdp_pwr_t;
	typedef enum logic [1:0] {
		TCDP_HS_IDLE = 2'h0,
		TCDP_HS_LO = 2'h1,
		TCDP_HS_HI = 2'h2,
		TCDP_HS_STROBE = 2'h3
	} tcdp_hstate_t;
endpackage : tcdp_pkg

// [include/tcdp_if.sv]
// pin bundle between the codec device end and its host controller
// assumes every pin is driven by exactly one end; no tristate pins
`timescale 1ns/1ps
`default_nettype none
interface tcdp_if;
	logic pcm_bclk;
	logic pcm_fsync;
	logic pcm_rx_data;
	logic pcm_tx_data;
	logic ctrl_serial_data;
	logic ctrl_shift_clock;
	logic latch_strobe;
	logic latch_reset_n;
	logic power_select_0;
	logic power_select_1;
	logic power_select_2;
	logic tone_ref_clock;
	logic tone_gate;
	modport dev (
		input pcm_bclk, pcm_fsync, pcm_rx_data, ctrl_serial_data, ctrl_shift_clock,
		input latch_strobe, latch_reset_n, power_select_0, power_select_1, power_select_2,
		input tone_ref_clock, tone_gate,
		output pcm_tx_data
	);
	modport host (
		output pcm_bclk, pcm_fsync, pcm_rx_data, ctrl_serial_data, ctrl_shift_clock,
		output latch_strobe, latch_reset_n, power_select_0, power_select_1, power_select_2,
		output tone_ref_clock, tone_gate,
		input pcm_tx_data
	);
endinterface : tcdp_if
`default_nettype wire

// [rtl/tcdp_device.sv]
// codec device end: pcm port, serial control latches, power select, tone clock
// assumes all link pins are asynchronous to mclk_i and slow against 4 ns
// Functional notes
// - frame sync must be 8 kHz, else codec off
// - host bit clock within allowed rate range
// - stalled bit clock powers codec down
// - receive bit sampled on bit clock fall
// - transmit bit launched on bit clock rise
// - transmit pin high while codec is down
// - power select pins decode to four modes
// - control bit captured on shift clock rise
// - low strobe commits word to addressed register
// - low latch reset initialises control latches
// - parallel latch pins follow register 8 bits 3:0
// - tone clock divided by one, two, four
// - tone output only while tone gate high
// - accessory switch follows register 7 bit 0
// - word is 4-bit address, 5 data
// - latches kept through power-down selections
// - pcm field picks mu-law, A-law, linear
// - switch closed on 1, open on 0
`timescale 1ns/1ps
`default_nettype none
`include "tcdp_params.svh"
module tcdp_device #(
	parameter int FSYNC_PERIOD_CYC = `TCDP_FSYNC_CYC,
	parameter int FSYNC_TOL_CYC = `TCDP_FSYNC_TOL_CYC,
	parameter int STALL_CYC = `TCDP_BCLK_STALL_CYC
) (
	input wire logic mclk_i,
	input wire logic srst_i,
	tcdp_if.dev link,
	input wire logic [15:0] tx_sample_i,
	output logic tx_load_o,
	output logic [15:0] rx_sample_o,
	output logic rx_valid_o,
	output logic codec_active_o,
	output var tcdp_pkg::tcdp_pwr_t pwr_mode_o,
	output var tcdp_pkg::tcdp_pcm_mode_t pcm_mode_o,
	output logic [3:0] ext_latch_out_o,
	output logic accessory_analog_switch_o,
	output logic tone_tick_o,
	output logic tone_out_o
);
	localparam int NS = 12;
	localparam int I_BCLK = 0;
	localparam int I_FS = 1;
	localparam int I_RXD = 2;
	localparam int I_SCLK = 3;
	localparam int I_SDAT = 4;
	localparam int I_STB = 5;
	localparam int I_RSTN = 6;
	localparam int I_TREF = 7;
	localparam int I_TGATE = 8;
	localparam int I_PS = 9;

	generate
		if (FSYNC_TOL_CYC < 1 || FSYNC_TOL_CYC >= FSYNC_PERIOD_CYC ||
			FSYNC_PERIOD_CYC + FSYNC_TOL_CYC >= (1 << 18) || STALL_CYC < 1 || STALL_CYC >= 4096) begin : g_bad
			$error("tcdp_device: timing parameters out of range");
		end
	endgenerate

	localparam logic [17:0] FS_LO = 18'(FSYNC_PERIOD_CYC - FSYNC_TOL_CYC);
	localparam logic [17:0] FS_HI = 18'(FSYNC_PERIOD_CYC + FSYNC_TOL_CYC);
	localparam logic [11:0] STALL_W = 12'(STALL_CYC);

	logic [NS-1:0] pins;
	logic [NS-1:0] meta_reg;
	logic [NS-1:0] sync_reg;
	logic [NS-1:0] prev_reg;

	assign pins = {link.power_select_2, link.power_select_1, link.power_select_0,
		link.tone_gate, link.tone_ref_clock, link.latch_reset_n, link.latch_strobe,
		link.ctrl_serial_data, link.ctrl_shift_clock, link.pcm_rx_data, link.pcm_fsync,
		link.pcm_bclk};

	// edges are found on the second stage against a third, never on the first
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			meta_reg <= 12'h060;
			sync_reg <= 12'h060;
			prev_reg <= 12'h060;
		end else begin
			meta_reg <= pins;
			sync_reg <= meta_reg;
			prev_reg <= sync_reg;
		end
	end

	logic bclk_rise;
	logic bclk_fall;
	logic sclk_rise;
	logic tref_rise;
	logic fs_rise;
	logic [2:0] ps;
	assign bclk_rise = sync_reg[I_BCLK] & ~prev_reg[I_BCLK];
	assign bclk_fall = ~sync_reg[I_BCLK] & prev_reg[I_BCLK];
	assign sclk_rise = sync_reg[I_SCLK] & ~prev_reg[I_SCLK];
	assign tref_rise = sync_reg[I_TREF] & ~prev_reg[I_TREF];
	assign fs_rise = sync_reg[I_FS] & ~prev_reg[I_FS];
	assign ps = sync_reg[I_PS+2:I_PS];

	// control latches
	logic [8:0] shift_reg;
	logic [8:0] shift_next;
	logic [4:0] acc_reg;
	logic [4:0] acc_next;
	logic [4:0] par_reg;
	logic [4:0] par_next;
	logic [4:0] tone_reg;
	logic [4:0] tone_next;
	logic [1:0] pcm_reg;
	logic [1:0] pcm_next;

	always_comb begin
		shift_next = shift_reg;
		acc_next = acc_reg;
		par_next = par_reg;
		tone_next = tone_reg;
		pcm_next = pcm_reg;
		if (sclk_rise) begin
			shift_next = {shift_reg[7:0], sync_reg[I_SDAT]};
		end
		if (!sync_reg[I_RSTN]) begin
			acc_next = `TCDP_RST_ACC;
			par_next = `TCDP_RST_PAR;
			tone_next = `TCDP_RST_TONE;
			pcm_next = `TCDP_RST_PCM;
		end else if (!sync_reg[I_STB]) begin
			// the last nine bits shifted are the word; older bits fell off the top
			case (shift_reg[8:`TCDP_ADDR_LSB])
				`TCDP_ADDR_ACC: acc_next = shift_reg[4:0];
				`TCDP_ADDR_PAR: par_next = shift_reg[4:0];
				`TCDP_ADDR_TONE: tone_next = shift_reg[4:0];
				`TCDP_ADDR_PCM: pcm_next = shift_reg[1:0];
				default: acc_next = acc_reg;
			endcase
		end
	end

	// power selection never touches the latches, only the strobe, the latch reset and srst_i do
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			shift_reg <= 9'h000;
			acc_reg <= `TCDP_RST_ACC;
			par_reg <= `TCDP_RST_PAR;
			tone_reg <= `TCDP_RST_TONE;
			pcm_reg <= `TCDP_RST_PCM;
		end else begin
			shift_reg <= shift_next;
			acc_reg <= acc_next;
			par_reg <= par_next;
			tone_reg <= tone_next;
			pcm_reg <= pcm_next;
		end
	end

	assign ext_latch_out_o = par_reg[3:0];
	assign accessory_analog_switch_o = acc_reg[`TCDP_ACC_SW_BIT];
	assign pcm_mode_o = tcdp_pkg::tcdp_pcm_mode_t'(pcm_reg);

	// power mode and link health
	tcdp_pkg::tcdp_pwr_t pwr_reg;
	tcdp_pkg::tcdp_pwr_t pwr_next;
	logic [11:0] stall_reg;
	logic [11:0] stall_next;
	logic [17:0] fscnt_reg;
	logic [17:0] fscnt_next;
	logic fsok_reg;
	logic fsok_next;
	logic codec_on;

	always_comb begin
		if (ps[0]) begin
			pwr_next = tcdp_pkg::TCDP_PWR_ALL;
		end else if (ps[1]) begin
			pwr_next = tcdp_pkg::TCDP_PWR_TONE;
		end else if (ps[2]) begin
			pwr_next = tcdp_pkg::TCDP_PWR_VREF;
		end else begin
			pwr_next = tcdp_pkg::TCDP_PWR_OFF;
		end
		stall_next = stall_reg;
		if (bclk_rise || bclk_fall) begin
			stall_next = 12'h000;
		end else if (stall_reg < STALL_W) begin
			stall_next = stall_reg + 12'h001;
		end
		fsok_next = fsok_reg;
		fscnt_next = fscnt_reg;
		if (fs_rise) begin
			fsok_next = (fscnt_reg >= FS_LO) && (fscnt_reg <= FS_HI);
			fscnt_next = 18'h00000;
		end else if (fscnt_reg > FS_HI) begin
			fsok_next = 1'b0;
		end else begin
			fscnt_next = fscnt_reg + 18'h00001;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			pwr_reg <= tcdp_pkg::TCDP_PWR_OFF;
			stall_reg <= 12'h000;
			fscnt_reg <= 18'h00000;
			fsok_reg <= 1'b0;
		end else begin
			pwr_reg <= pwr_next;
			stall_reg <= stall_next;
			fscnt_reg <= fscnt_next;
			fsok_reg <= fsok_next;
		end
	end

	assign pwr_mode_o = pwr_reg;
	assign codec_on = (pwr_reg == tcdp_pkg::TCDP_PWR_ALL) && fsok_reg && (stall_reg < STALL_W);
	assign codec_active_o = codec_on;

	// pcm serial port
	logic fsprev_reg;
	logic fsprev_next;
	logic [15:0] txsh_reg;
	logic [15:0] txsh_next;
	logic [4:0] txleft_reg;
	logic [4:0] txleft_next;
	logic txd_reg;
	logic txd_next;
	logic txload_reg;
	logic txload_next;
	logic rxact_reg;
	logic rxact_next;
	logic [4:0] rxcnt_reg;
	logic [4:0] rxcnt_next;
	logic [15:0] rxsh_reg;
	logic [15:0] rxsh_next;
	logic [15:0] rxword_reg;
	logic [15:0] rxword_next;
	logic rxval_reg;
	logic rxval_next;
	logic [4:0] nbits;
	logic [15:0] txword;

	assign nbits = (pcm_reg == 2'(tcdp_pkg::TCDP_PCM_LINEAR)) ? `TCDP_BITS_LIN : `TCDP_BITS_COMP;
	// companded samples travel in the low byte of the user word
	assign txword = (nbits == `TCDP_BITS_LIN) ? tx_sample_i : {tx_sample_i[7:0], 8'h00};

	always_comb begin
		fsprev_next = fsprev_reg;
		txsh_next = txsh_reg;
		txleft_next = txleft_reg;
		txd_next = txd_reg;
		txload_next = 1'b0;
		rxact_next = rxact_reg;
		rxcnt_next = rxcnt_reg;
		rxsh_next = rxsh_reg;
		rxword_next = rxword_reg;
		rxval_next = 1'b0;
		if (!codec_on) begin
			txd_next = 1'b1;
			txleft_next = 5'h00;
			rxact_next = 1'b0;
			fsprev_next = 1'b1;
		end else begin
			if (bclk_rise) begin
				fsprev_next = sync_reg[I_FS];
				if (sync_reg[I_FS] && !fsprev_reg) begin
					txd_next = txword[15];
					txsh_next = {txword[14:0], 1'b0};
					txleft_next = nbits - 5'h01;
					txload_next = 1'b1;
					rxact_next = 1'b1;
					rxcnt_next = 5'h00;
					rxsh_next = 16'h0000;
				end else if (txleft_reg != 5'h00) begin
					txd_next = txsh_reg[15];
					txsh_next = {txsh_reg[14:0], 1'b0};
					txleft_next = txleft_reg - 5'h01;
				end else begin
					txd_next = 1'b1;
				end
			end
			if (bclk_fall && rxact_reg) begin
				rxsh_next = {rxsh_reg[14:0], sync_reg[I_RXD]};
				rxcnt_next = rxcnt_reg + 5'h01;
				if (rxcnt_reg == nbits - 5'h01) begin
					rxact_next = 1'b0;
					rxval_next = 1'b1;
					rxword_next = {rxsh_reg[14:0], sync_reg[I_RXD]};
				end
			end
		end
	end

	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			fsprev_reg <= 1'b1;
			txsh_reg <= 16'h0000;
			txleft_reg <= 5'h00;
			txd_reg <= 1'b1;
			txload_reg <= 1'b0;
			rxact_reg <= 1'b0;
			rxcnt_reg <= 5'h00;
			rxsh_reg <= 16'h0000;
			rxword_reg <= 16'h0000;
			rxval_reg <= 1'b0;
		end else begin
			fsprev_reg <= fsprev_next;
			txsh_reg <= txsh_next;
			txleft_reg <= txleft_next;
			txd_reg <= txd_next;
			txload_reg <= txload_next;
			rxact_reg <= rxact_next;
			rxcnt_reg <= rxcnt_next;
			rxsh_reg <= rxsh_next;
			rxword_reg <= rxword_next;
			rxval_reg <= rxval_next;
		end
	end

	assign link.pcm_tx_data = txd_reg;
	assign tx_load_o = txload_reg;
	assign rx_sample_o = rxword_reg;
	assign rx_valid_o = rxval_reg;

	// tone clock divider, counted in tone reference rising edges
	logic [1:0] tdiv_reg;
	logic [1:0] tdiv_next;
	logic tick_reg;
	logic tick_next;
	logic tout_reg;
	logic tout_next;
	logic [1:0] tdiv_max;
	logic tone_pwr;

	assign tone_pwr = (pwr_reg == tcdp_pkg::TCDP_PWR_TONE) || (pwr_reg == tcdp_pkg::TCDP_PWR_ALL);

	always_comb begin
		case (tone_reg[`TCDP_TONE_DIV_LSB+1:`TCDP_TONE_DIV_LSB])
			2'h0: tdiv_max = 2'h0;
			2'h1: tdiv_max = 2'h1;
			default: tdiv_max = 2'h3;
		endcase
		tdiv_next = tdiv_reg;
		tick_next = 1'b0;
		if (tref_rise && tone_pwr) begin
			if (tdiv_reg >= tdiv_max) begin
				tdiv_next = 2'h0;
				tick_next = 1'b1;
			end else begin
				tdiv_next = tdiv_reg + 2'h1;
			end
		end
		tout_next = tone_pwr && sync_reg[I_TGATE];
	end

	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			tdiv_reg <= 2'h0;
			tick_reg <= 1'b0;
			tout_reg <= 1'b0;
		end else begin
			tdiv_reg <= tdiv_next;
			tick_reg <= tick_next;
			tout_reg <= tout_next;
		end
	end

	assign tone_tick_o = tick_reg;
	assign tone_out_o = tout_reg;
endmodule : tcdp_device
`default_nettype wire

// [rtl/tcdp_host.sv]
// host controller end: makes bit clock and frame sync, shifts control words
// assumes software on the plain register port; device answers asynchronously
`timescale 1ns/1ps
`default_nettype none
`include "tcdp_params.svh"
module tcdp_host #(
	parameter int BCLK_HALF_CYC = `TCDP_H_BCLK_HALF_CYC,
	parameter int FRAME_BITS = `TCDP_FRAME_BITS,
	parameter int SCLK_HALF_CYC = `TCDP_H_SCLK_HALF_CYC,
	parameter int STB_CYC = `TCDP_H_STB_CYC,
	parameter int TREF_HALF_CYC = `TCDP_H_TREF_HALF_CYC
) (
	input wire logic mclk_i,
	input wire logic srst_i,
	tcdp_if.host link,
	input wire logic [3:0] reg_addr_i,
	input wire logic [15:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [15:0] reg_rdata_o
);
	generate
		if (BCLK_HALF_CYC < 2 || BCLK_HALF_CYC > 255 || FRAME_BITS < 17 || FRAME_BITS > 512 ||
			SCLK_HALF_CYC < 4 || SCLK_HALF_CYC > 255 || STB_CYC < 4 || STB_CYC > 255 ||
			TREF_HALF_CYC < 2 || TREF_HALF_CYC > 255) begin : g_bad
			$error("tcdp_host: timing parameters out of range");
		end
	endgenerate

	localparam logic [7:0] BH = 8'(BCLK_HALF_CYC - 1);
	localparam logic [8:0] FB = 9'(FRAME_BITS - 1);
	localparam logic [7:0] SH = 8'(SCLK_HALF_CYC - 1);
	localparam logic [7:0] SB = 8'(STB_CYC - 1);
	localparam logic [7:0] TH = 8'(TREF_HALF_CYC - 1);

	logic txd_meta_reg;
	logic txd_sync_reg;
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			txd_meta_reg <= 1'b1;
			txd_sync_reg <= 1'b1;
		end else begin
			txd_meta_reg <= link.pcm_tx_data;
			txd_sync_reg <= txd_meta_reg;
		end
	end

	logic [15:0] ctrl_reg, ctrl_next, htx_reg, htx_next, hrx_reg, hrx_next, rdata_reg, rdata_next;
	logic rxnew_reg, rxnew_next, rxdone;
	logic [15:0] rxw;
	logic [8:0] cmd_reg, cmd_next;
	logic [7:0] bdiv_reg, bdiv_next, sdiv_reg, sdiv_next, tdiv_reg, tdiv_next;
	logic [8:0] bit_reg, bit_next;
	logic bclk_reg, bclk_next, fs_reg, fs_next, txd_reg, txd_next, tref_reg, tref_next;
	logic [15:0] txsh_reg, txsh_next, rxsh_reg, rxsh_next;
	logic [4:0] left_reg, left_next, rcnt_reg, rcnt_next, nbits;
	logic ract_reg, ract_next;
	logic [3:0] sbit_reg, sbit_next;
	logic sclk_reg, sclk_next, sdat_reg, sdat_next, stb_reg, stb_next;
	tcdp_pkg::tcdp_hstate_t st_reg, st_next;

	assign nbits = ctrl_reg[`TCDP_HC_LINEAR] ? `TCDP_BITS_LIN : `TCDP_BITS_COMP;

	// register port; the rx sample flag lets a new sample win over a clearing read
	always_comb begin
		ctrl_next = ctrl_reg;
		htx_next = htx_reg;
		hrx_next = rxdone ? rxw : hrx_reg;
		rxnew_next = rxnew_reg;
		rdata_next = 16'h0000;
		if (reg_wr_i && reg_addr_i == `TCDP_H_CTRL) begin
			ctrl_next = reg_wdata_i;
		end
		if (reg_wr_i && reg_addr_i == `TCDP_H_TX) begin
			htx_next = reg_wdata_i;
		end
		if (reg_rd_i) begin
			case (reg_addr_i)
				`TCDP_H_CTRL: rdata_next = ctrl_reg;
				`TCDP_H_STAT: rdata_next = {14'h0000, rxnew_reg, st_reg != tcdp_pkg::TCDP_HS_IDLE};
				`TCDP_H_TX: rdata_next = htx_reg;
				`TCDP_H_RX: rdata_next = hrx_reg;
				default: rdata_next = 16'h0000;
			endcase
			if (reg_addr_i == `TCDP_H_RX) begin
				rxnew_next = 1'b0;
			end
		end
		if (rxdone) begin
			rxnew_next = 1'b1;
		end
	end

	// pcm master: bit clock divider, sync a half bit ahead of bit 0
	always_comb begin
		bdiv_next = bdiv_reg + 8'h01;
		bclk_next = bclk_reg;
		bit_next = bit_reg;
		fs_next = fs_reg;
		txd_next = txd_reg;
		txsh_next = txsh_reg;
		left_next = left_reg;
		ract_next = ract_reg;
		rcnt_next = rcnt_reg;
		rxsh_next = rxsh_reg;
		rxdone = 1'b0;
		rxw = {rxsh_reg[14:0], txd_sync_reg};
		if (!ctrl_reg[`TCDP_HC_LINK_EN]) begin
			bdiv_next = 8'h00;
			bclk_next = 1'b0;
			fs_next = 1'b0;
			bit_next = FB;
			ract_next = 1'b0;
		end else if (bdiv_reg == BH) begin
			bdiv_next = 8'h00;
			bclk_next = ~bclk_reg;
			if (!bclk_reg) begin
				bit_next = (bit_reg == FB) ? 9'h000 : bit_reg + 9'h001;
				if (bit_reg == FB) begin
					txd_next = ctrl_reg[`TCDP_HC_LINEAR] ? htx_reg[15] : htx_reg[7];
					txsh_next = ctrl_reg[`TCDP_HC_LINEAR] ? {htx_reg[14:0], 1'b0} : {htx_reg[6:0], 9'h000};
					left_next = nbits - 5'h01;
					ract_next = 1'b1;
					rcnt_next = 5'h00;
					rxsh_next = 16'h0000;
				end else if (left_reg != 5'h00) begin
					txd_next = txsh_reg[15];
					txsh_next = {txsh_reg[14:0], 1'b0};
					left_next = left_reg - 5'h01;
				end
			end else begin
				// high from the fall before the bit-0 rise to the fall after it, so the
				// device sees exactly one rise with sync high and the frames line up
				fs_next = (bit_reg == FB);
				if (ract_reg) begin
					rxsh_next = rxw;
					rcnt_next = rcnt_reg + 5'h01;
					if (rcnt_reg == nbits - 5'h01) begin
						ract_next = 1'b0;
						rxdone = 1'b1;
					end
				end
			end
		end
	end

	// control word shifter: address then data, msb first, then strobe low
	always_comb begin
		st_next = st_reg;
		sdiv_next = sdiv_reg + 8'h01;
		sbit_next = sbit_reg;
		cmd_next = cmd_reg;
		sclk_next = sclk_reg;
		sdat_next = sdat_reg;
		stb_next = stb_reg;
		tdiv_next = (tdiv_reg == TH) ? 8'h00 : tdiv_reg + 8'h01;
		tref_next = (tdiv_reg == TH) ? ~tref_reg : tref_reg;
		case (st_reg)
			tcdp_pkg::TCDP_HS_IDLE: begin
				sdiv_next = 8'h00;
				if (reg_wr_i && reg_addr_i == `TCDP_H_CMD) begin
					cmd_next = reg_wdata_i[8:0];
					sbit_next = 4'h0;
					st_next = tcdp_pkg::TCDP_HS_LO;
				end
			end
			tcdp_pkg::TCDP_HS_LO: begin
				sclk_next = 1'b0;
				sdat_next = cmd_reg[8];
				if (sdiv_reg == SH) begin
					sdiv_next = 8'h00;
					st_next = tcdp_pkg::TCDP_HS_HI;
				end
			end
			tcdp_pkg::TCDP_HS_HI: begin
				sclk_next = 1'b1;
				if (sdiv_reg == SH) begin
					sdiv_next = 8'h00;
					sclk_next = 1'b0;
					cmd_next = {cmd_reg[7:0], 1'b0};
					sbit_next = sbit_reg + 4'h1;
					st_next = (sbit_reg == 4'(`TCDP_WORD_BITS - 1)) ? tcdp_pkg::TCDP_HS_STROBE
						: tcdp_pkg::TCDP_HS_LO;
				end
			end
			tcdp_pkg::TCDP_HS_STROBE: begin
				stb_next = 1'b0;
				if (sdiv_reg == SB) begin
					stb_next = 1'b1;
					st_next = tcdp_pkg::TCDP_HS_IDLE;
				end
			end
			default: st_next = tcdp_pkg::TCDP_HS_IDLE;
		endcase
	end

	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			ctrl_reg <= `TCDP_H_CTRL_RST;
			htx_reg <= 16'h0000;
			hrx_reg <= 16'h0000;
			rxnew_reg <= 1'b0;
			rdata_reg <= 16'h0000;
			bdiv_reg <= 8'h00;
			bclk_reg <= 1'b0;
			bit_reg <= 9'h000;
			fs_reg <= 1'b0;
			txd_reg <= 1'b1;
			txsh_reg <= 16'h0000;
			left_reg <= 5'h00;
			ract_reg <= 1'b0;
			rcnt_reg <= 5'h00;
			rxsh_reg <= 16'h0000;
			st_reg <= tcdp_pkg::TCDP_HS_IDLE;
			sdiv_reg <= 8'h00;
			sbit_reg <= 4'h0;
			cmd_reg <= 9'h000;
			sclk_reg <= 1'b0;
			sdat_reg <= 1'b0;
			stb_reg <= 1'b1;
			tdiv_reg <= 8'h00;
			tref_reg <= 1'b0;
		end else begin
			ctrl_reg <= ctrl_next;
			htx_reg <= htx_next;
			hrx_reg <= hrx_next;
			rxnew_reg <= rxnew_next;
			rdata_reg <= rdata_next;
			bdiv_reg <= bdiv_next;
			bclk_reg <= bclk_next;
			bit_reg <= bit_next;
			fs_reg <= fs_next;
			txd_reg <= txd_next;
			txsh_reg <= txsh_next;
			left_reg <= left_next;
			ract_reg <= ract_next;
			rcnt_reg <= rcnt_next;
			rxsh_reg <= rxsh_next;
			st_reg <= st_next;
			sdiv_reg <= sdiv_next;
			sbit_reg <= sbit_next;
			cmd_reg <= cmd_next;
			sclk_reg <= sclk_next;
			sdat_reg <= sdat_next;
			stb_reg <= stb_next;
			tdiv_reg <= tdiv_next;
			tref_reg <= tref_next;
		end
	end

	assign reg_rdata_o = rdata_reg;
	assign link.pcm_bclk = bclk_reg;
	assign link.pcm_fsync = fs_reg;
	assign link.pcm_rx_data = txd_reg;
	assign link.ctrl_shift_clock = sclk_reg;
	assign link.ctrl_serial_data = sdat_reg;
	assign link.latch_strobe = stb_reg;
	assign link.latch_reset_n = ctrl_reg[`TCDP_HC_LRST_N];
	assign link.power_select_0 = ctrl_reg[`TCDP_HC_PS_LSB];
	assign link.power_select_1 = ctrl_reg[`TCDP_HC_PS_LSB+1];
	assign link.power_select_2 = ctrl_reg[`TCDP_HC_PS_LSB+2];
	assign link.tone_gate = ctrl_reg[`TCDP_HC_GATE];
	assign link.tone_ref_clock = tref_reg;
endmodule : tcdp_host
`default_nettype wire

// [tb/tcdp_checker.sv]
// pin checker for the codec link between the two ends
// assumes bench values: bclk half 8, frame 18 bits, shift half 16, strobe 4
`timescale 1ns/1ps
`default_nettype none
module tcdp_checker (
	input wire logic mclk_i,
	input wire logic srst_i,
	input wire logic pcm_bclk,
	input wire logic pcm_fsync,
	input wire logic pcm_rx_data,
	input wire logic pcm_tx_data,
	input wire logic ctrl_shift_clock,
	input wire logic latch_strobe
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (srst_i);
	a_tx_idle_rst: assert property (disable iff (1'b0) srst_i |=> pcm_tx_data)
		else $error("tx not high in reset");
	a_tx_on_rise: assert property ($fell(pcm_tx_data) |-> $past(pcm_bclk, 3))
		else $error("tx moved off bit clock rise");
	a_rx_on_rise: assert property ($changed(pcm_rx_data) |-> pcm_bclk)
		else $error("rx moved while bit clock low");
	a_bclk_half: assert property ($rose(pcm_bclk) |-> pcm_bclk[*8] ##1 !pcm_bclk)
		else $error("bit clock half period wrong");
	a_fsync_rate: assert property ($rose(pcm_fsync) |-> ##288 $rose(pcm_fsync))
		else $error("frame sync period wrong");
	a_shift_stb_high: assert property ($rose(ctrl_shift_clock) |-> latch_strobe)
		else $error("shift while strobe low");
	a_stb_width: assert property ($fell(latch_strobe) |-> (!latch_strobe)[*3] ##1 latch_strobe)
		else $error("strobe width wrong");
	a_sclk_half: assert property ($rose(ctrl_shift_clock) |-> ##15 $fell(ctrl_shift_clock))
		else $error("shift clock half period wrong");
endmodule : tcdp_checker
`default_nettype wire

// [tb/testbench.sv]
// bench: host and device ends joined over the pin bundle, software side driven here
// assumes short frame (18 bits of 16 cycles) so sync checks fit a short run
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic mclk_i = 1'b0;
	logic srst_i = 1'b1;
	logic [3:0] reg_addr_i = 4'h0;
	logic [15:0] reg_wdata_i = 16'h0000;
	logic reg_wr_i = 1'b0;
	logic reg_rd_i = 1'b0;
	logic [15:0] tx_sample_i = 16'h0000;
	logic [15:0] reg_rdata_o, rx_sample_o, d, v, mask;
	logic codec_active_o, accessory_analog_switch_o, tone_tick_o, tone_out_o, tx_load_o, rx_valid_o;
	logic [3:0] ext_latch_out_o;
	logic [1:0] m, p;
	tcdp_pkg::tcdp_pwr_t pwr_mode_o;
	tcdp_pkg::tcdp_pcm_mode_t pcm_mode_o;
	int failures = 0, comparisons = 0, seed = 32'hdb97, i, n, ticks, nv, nl;
	tcdp_if link();
	// half bit of 8 leaves room for the device's launch delay plus the host's syncs
	tcdp_host #(.BCLK_HALF_CYC(8), .FRAME_BITS(18), .STB_CYC(4)) tcdp_host_i (.mclk_i(mclk_i),
		.srst_i(srst_i), .link(link.host),
		.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
		.reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o));
	tcdp_device #(.FSYNC_PERIOD_CYC(288), .STALL_CYC(24)) tcdp_device_i (
		.mclk_i(mclk_i), .srst_i(srst_i), .link(link.dev), .tx_sample_i(tx_sample_i),
		.tx_load_o(tx_load_o), .rx_sample_o(rx_sample_o), .rx_valid_o(rx_valid_o),
		.codec_active_o(codec_active_o),
		.pwr_mode_o(pwr_mode_o), .pcm_mode_o(pcm_mode_o), .ext_latch_out_o(ext_latch_out_o),
		.accessory_analog_switch_o(accessory_analog_switch_o), .tone_tick_o(tone_tick_o),
		.tone_out_o(tone_out_o));
	tcdp_checker tcdp_checker_i (.mclk_i(mclk_i), .srst_i(srst_i), .pcm_bclk(link.pcm_bclk),
		.pcm_fsync(link.pcm_fsync), .pcm_rx_data(link.pcm_rx_data),
		.pcm_tx_data(link.pcm_tx_data), .ctrl_shift_clock(link.ctrl_shift_clock),
		.latch_strobe(link.latch_strobe));
	initial begin
		forever #2 mclk_i = ~mclk_i;
	end
	always @(posedge mclk_i) begin
		if (tone_tick_o === 1'b1) ticks++;
		if (rx_valid_o === 1'b1) nv++;
		if (tx_load_o === 1'b1) nl++;
	end
	task automatic finish_test;
		if (failures == 0 && comparisons > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : finish_test
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic cyc(input int k);
		repeat (k) @(posedge mclk_i);
		#1;
	endtask : cyc
	task automatic wr(input logic [3:0] a, input logic [15:0] w);
		@(posedge mclk_i);
		reg_addr_i <= a;
		reg_wdata_i <= w;
		reg_wr_i <= 1'b1;
		@(posedge mclk_i);
		reg_wr_i <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a);
		@(posedge mclk_i);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge mclk_i);
		reg_rd_i <= 1'b0;
		#1 d = reg_rdata_o;
	endtask : rd
	// shifter busy is polled with a bound, then the latch gets time to settle
	task automatic word(input logic [3:0] a, input logic [4:0] w);
		wr(4'h1, {7'h00, a, w});
		n = 0;
		d = 16'h0001;
		while (d[0] !== 1'b0 && n < 300) begin
			rd(4'h2);
			n++;
		end
		if (n == 300) begin
			failures++;
			finish_test();
		end
		cyc(12);
	endtask : word
	initial begin
		repeat (5) @(posedge mclk_i);
		srst_i <= 1'b0;
		cyc(2);
		chk(16'(codec_active_o), 16'h0000);
		wr(4'h0, 16'h0045);
		for (i = 0; i < 3; i++) begin
			m = (i == 0) ? 2'h0 : ((i == 1) ? 2'h2 : 2'h1);
			word(4'hF, {3'h0, m});
			wr(4'h0, 16'h0045 | {14'h0000, m[0], 1'b0});
			v = 16'($random(seed));
			wr(4'h3, v);
			tx_sample_i <= 16'($random(seed));
			nv = 0;
			nl = 0;
			cyc(1024);
			mask = m[0] ? 16'hFFFF : 16'h00FF;
			chk(16'(pcm_mode_o), 16'(m));
			chk(16'(nv >= 2 && nv <= 4 && nl >= 2 && nl <= 4), 16'h0001);
			chk(rx_sample_o, v & mask);
			rd(4'h4);
			chk(d, tx_sample_i & mask);
		end
		for (i = 0; i < 4; i++) begin
			v = 16'($random(seed));
			word(4'h8, v[4:0]);
			word(4'h7, v[9:5]);
			word(4'h3, v[14:10]);
			chk(16'(ext_latch_out_o), 16'(v[3:0]));
			chk(16'(accessory_analog_switch_o), 16'(v[5]));
		end
		for (i = 0; i < 3; i++) begin
			word(4'hE, 5'(i << 3));
			ticks = 0;
			cyc(512);
			chk(16'(ticks >= (32 >> i) - 1 && ticks <= (32 >> i) + 1), 16'h0001);
		end
		for (i = 0; i < 2; i++) begin
			wr(4'h0, 16'h0045 | 16'(i << 5));
			cyc(8);
			chk(16'(tone_out_o), 16'(i));
		end
		for (i = 0; i < 8; i++) begin
			wr(4'h0, 16'h0041 | 16'(i << 2));
			cyc(300);
			p = i[0] ? 2'h3 : (i[1] ? 2'h2 : (i[2] ? 2'h1 : 2'h0));
			chk(16'(pwr_mode_o), 16'(p));
			chk(16'(link.pcm_tx_data | i[0]), 16'h0001);
			chk(16'(ext_latch_out_o), 16'(v[3:0]));
		end
		wr(4'h0, 16'h0005);
		cyc(10);
		chk(16'({ext_latch_out_o, accessory_analog_switch_o}), 16'h0000);
		chk(16'(codec_active_o), 16'h0001);
		// stop the link just after a sync rise, while the bit clock is low
		n = 0;
		while (link.pcm_fsync !== 1'b0 && n < 600) begin
			cyc(1);
			n++;
		end
		while (link.pcm_fsync !== 1'b1 && n < 600) begin
			cyc(1);
			n++;
		end
		if (n == 600) begin
			failures++;
			finish_test();
		end
		wr(4'h0, 16'h0044);
		cyc(40);
		chk(16'(codec_active_o), 16'h0000);
		finish_test();
	end
endmodule : testbench
`default_nettype wire
